// ==== event_latch.sv ====
// Purpose: wake-up event latch for wait-for-event
// Assumes: pending edges and send-event pulses arrive synchronous to aclk
// Notes:   a set in the same cycle as a consume is kept for the next wait
`timescale 1ns/100ps
module event_latch (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic wake_any,
    input  wire logic enabled_event,
    input  wire logic any_pending_rise,
    input  wire logic send_event_instr,
    input  wire logic consume,
    output logic      event_q
);
    logic event_d;
    logic set_ev;

    always_comb begin
        set_ev  = enabled_event | send_event_instr | (wake_any & any_pending_rise);
        event_d = set_ev | (event_q & ~consume);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            event_q <= 1'b0;
        end else begin
            event_q <= event_d;
        end
    end

    property p_set_kept;
        @(posedge aclk) disable iff (!aresetn)
        set_ev |=> event_q;
    endproperty
    a_set_kept: assert property (p_set_kept) else $error("event set was lost");
    property p_disabled_ignored;
        @(posedge aclk) disable iff (!aresetn)
        (!event_q && !wake_any && !enabled_event && !send_event_instr) |=> !event_q;
    endproperty
    a_disabled_ignored: assert property (p_disabled_ignored) else $error("disabled pending woke core");
endmodule : event_latch

// ==== sys_ctrl_pkg.sv ====
// Purpose: shared constants and carrier types for the system control register bank
// Assumes: axi4-lite slave, 32-bit data, one aligned word per register
// Notes:   offsets are local choices; the register bank decodes all five address bits [4:0]
package sys_ctrl_pkg;

    localparam logic [4:0]  OFS_RESET_CONTROL = 5'h00;
    localparam logic [4:0]  OFS_LOW_POWER     = 5'h04;
    localparam logic [4:0]  OFS_CONFIG_STATUS = 5'h08;
    localparam logic [4:0]  OFS_PRIORITY_A    = 5'h0c;
    localparam logic [4:0]  OFS_PRIORITY_B    = 5'h10;

    localparam logic [15:0] WRITE_KEY_VALUE   = 16'h05fa;
    localparam int          KEY_MSB           = 31;
    localparam int          KEY_LSB           = 16;
    localparam int          BYTE_ORDER_POS    = 15;
    localparam int          RESET_REQ_POS     = 2;
    localparam int          DEBUG_RSVD_POS    = 1;
    localparam int          WAKE_ANY_POS      = 4;
    localparam int          DEEP_SLEEP_POS    = 2;
    localparam int          SLEEP_EXIT_POS    = 1;
    localparam int          STACK_ALIGN_POS   = 9;
    localparam int          MISALIGN_TRAP_POS = 3;
    localparam int          PRI_HI_POS        = 30;
    localparam int          PRI_MID_POS       = 22;
    localparam int          STATUS_ALIGN_POS  = 9;

    localparam logic        BYTE_ORDER_RESET  = 1'b0;
    localparam logic [1:0]  PRIORITY_RESET    = 2'h0;
    localparam logic [1:0]  RESP_OKAY         = 2'h0;
    localparam logic [1:0]  RESP_SLVERR       = 2'h2;

    typedef struct packed {
        logic       wake_any;
        logic       deep_sleep;
        logic       sleep_exit;
    } low_power_t;

    typedef struct packed {
        logic [1:0] supervisor_call;
        logic [1:0] pended_service;
        logic [1:0] tick;
    } priority_t;

    typedef enum logic [1:0] {
        CORE_RUN   = 2'b00,
        CORE_SLEEP = 2'b01,
        CORE_WAIT  = 2'b10
    } core_state_t;

endpackage : sys_ctrl_pkg

// ==== sys_ctrl_regs.sv ====
// Purpose: system control registers (reset control, low power, config, handler priority)
// Assumes: axi4-lite master keeps at most one write and one read under way
// Notes:   all outputs are registered; unmapped addresses answer slverr
//
// Behaviour
// - writes to reset control ignored unless key field holds 0x05fa; key reads zero
// - bit 15 of reset control reports byte order, read only
// - keyed write of 1 to bit 2 pulses system reset request; reads 0
// - wake_on_any_pending set lets disabled pending interrupts wake the core
// - pending events wake wait-for-event or are latched for the next wait
// - send-event instruction always wakes wait-for-event
// - bit 2 of low power control selects sleep or deep sleep
// - bit 1 makes the core sleep on return from handler to thread
// - config register read only; bit 9 reads 1 for 8-byte stack alignment
// - stacked status bit 9 records padding on entry, restores alignment on return
// - config bit 3 reads 1; unaligned accesses raise hard fault
// - three handlers carry priorities of four levels, 0 to 3
// - priority fields keep bits 7:6 only; lower six bits read zero
// - first priority register holds supervisor call priority in bits 31:24
// - second register holds tick in 31:24 and pended service in 23:16
//
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
module sys_ctrl_regs (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [4:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [4:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        wait_for_event_instr,
    input  wire logic        wait_for_interrupt_instr,
    input  wire logic        send_event_instr,
    input  wire logic        enabled_event,
    input  wire logic        any_pending,
    input  wire logic        handler_to_thread,
    input  wire logic        exception_entry,
    input  wire logic        exception_return,
    input  wire logic        stack_misaligned,
    input  wire logic        stacked_align_bit,
    input  wire logic        unaligned_access,
    output logic             system_reset_request,
    output logic             core_sleeping,
    output logic             deep_sleep_select,
    output logic             hard_fault_exception,
    output logic             status_align_bit,
    output logic             stack_restore_pad,
    output logic [1:0]       supervisor_call_priority,
    output logic [1:0]       pended_service_priority,
    output logic [1:0]       tick_priority
);

    typedef struct packed {
        logic                      awready;
        logic                      wready;
        logic                      aw_held;
        logic [4:0]                aw_addr;
        logic                      w_held;
        logic [31:0]               w_data;
        logic [3:0]                w_strb;
        logic                      bvalid;
        logic [1:0]                bresp;
        logic                      arready;
        logic                      rvalid;
        logic [31:0]               rdata;
        logic [1:0]                rresp;
        logic                      byte_order;
        sys_ctrl_pkg::low_power_t  lp;
        sys_ctrl_pkg::priority_t   pri;
        logic                      reset_req;
        logic                      pending_prev;
        sys_ctrl_pkg::core_state_t core;
        logic                      hard_fault;
        logic                      align_bit;
        logic                      restore_pad;
        logic                      sleeping;
    } state_t;

    state_t st_q;
    state_t st_d;
    logic   event_q;
    logic   consume;
    logic   do_write;
    logic   do_read;
    logic   key_ok;
    logic   wr_full;

    event_latch u_event (
        .aclk             (aclk),
        .aresetn          (aresetn),
        .wake_any         (st_q.lp.wake_any),
        .enabled_event    (enabled_event),
        .any_pending_rise (any_pending & ~st_q.pending_prev),
        .send_event_instr (send_event_instr),
        .consume          (consume),
        .event_q          (event_q)
    );

    always_comb begin
        st_d     = st_q;
        consume  = 1'b0;
        do_write = st_q.aw_held & st_q.w_held & ~st_q.bvalid;
        do_read  = s_axi_arvalid & st_q.arready;
        wr_full  = &st_q.w_strb;
        key_ok   = st_q.w_data[sys_ctrl_pkg::KEY_MSB:sys_ctrl_pkg::KEY_LSB] == sys_ctrl_pkg::WRITE_KEY_VALUE;
        st_d.reset_req    = 1'b0;
        st_d.hard_fault   = unaligned_access;
        st_d.pending_prev = any_pending;

        // address and data captured independently, in either order
        if (s_axi_awvalid && st_q.awready) begin
            st_d.aw_held = 1'b1;
            st_d.aw_addr = s_axi_awaddr;
            st_d.awready = 1'b0;
        end
        if (s_axi_wvalid && st_q.wready) begin
            st_d.w_held = 1'b1;
            st_d.w_data = s_axi_wdata;
            st_d.w_strb = s_axi_wstrb;
            st_d.wready = 1'b0;
        end

        if (do_write) begin
            st_d.aw_held = 1'b0;
            st_d.w_held  = 1'b0;
            st_d.bvalid  = 1'b1;
            st_d.bresp   = sys_ctrl_pkg::RESP_OKAY;
            // partial-word writes to reset control and low power are dropped; priority registers follow their byte strobes
            case (st_q.aw_addr)
                sys_ctrl_pkg::OFS_RESET_CONTROL: begin
                    if (key_ok && wr_full) begin
                        st_d.reset_req = st_q.w_data[sys_ctrl_pkg::RESET_REQ_POS];
                    end
                end
                sys_ctrl_pkg::OFS_LOW_POWER: begin
                    if (wr_full) begin
                        st_d.lp.wake_any   = st_q.w_data[sys_ctrl_pkg::WAKE_ANY_POS];
                        st_d.lp.deep_sleep = st_q.w_data[sys_ctrl_pkg::DEEP_SLEEP_POS];
                        st_d.lp.sleep_exit = st_q.w_data[sys_ctrl_pkg::SLEEP_EXIT_POS];
                    end
                end
                sys_ctrl_pkg::OFS_CONFIG_STATUS: begin
                    st_d.bresp = sys_ctrl_pkg::RESP_OKAY;
                end
                sys_ctrl_pkg::OFS_PRIORITY_A: begin
                    if (st_q.w_strb[3]) begin
                        st_d.pri.supervisor_call = st_q.w_data[sys_ctrl_pkg::PRI_HI_POS +: 2];
                    end
                end
                sys_ctrl_pkg::OFS_PRIORITY_B: begin
                    if (st_q.w_strb[3]) begin
                        st_d.pri.tick = st_q.w_data[sys_ctrl_pkg::PRI_HI_POS +: 2];
                    end
                    if (st_q.w_strb[2]) begin
                        st_d.pri.pended_service = st_q.w_data[sys_ctrl_pkg::PRI_MID_POS +: 2];
                    end
                end
                default: begin
                    st_d.bresp = sys_ctrl_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid  = 1'b0;
            st_d.awready = 1'b1;
            st_d.wready  = 1'b1;
        end

        if (do_read) begin
            st_d.arready = 1'b0;
            st_d.rvalid  = 1'b1;
            st_d.rresp   = sys_ctrl_pkg::RESP_OKAY;
            st_d.rdata   = 32'h0000_0000;
            case (s_axi_araddr)
                sys_ctrl_pkg::OFS_RESET_CONTROL: begin
                    // key field, request bit and debug bit all read zero
                    st_d.rdata[sys_ctrl_pkg::BYTE_ORDER_POS] = st_q.byte_order;
                end
                sys_ctrl_pkg::OFS_LOW_POWER: begin
                    st_d.rdata[sys_ctrl_pkg::WAKE_ANY_POS]   = st_q.lp.wake_any;
                    st_d.rdata[sys_ctrl_pkg::DEEP_SLEEP_POS] = st_q.lp.deep_sleep;
                    st_d.rdata[sys_ctrl_pkg::SLEEP_EXIT_POS] = st_q.lp.sleep_exit;
                end
                sys_ctrl_pkg::OFS_CONFIG_STATUS: begin
                    st_d.rdata[sys_ctrl_pkg::STACK_ALIGN_POS]   = 1'b1;
                    st_d.rdata[sys_ctrl_pkg::MISALIGN_TRAP_POS] = 1'b1;
                end
                sys_ctrl_pkg::OFS_PRIORITY_A: begin
                    st_d.rdata[sys_ctrl_pkg::PRI_HI_POS +: 2] = st_q.pri.supervisor_call;
                end
                sys_ctrl_pkg::OFS_PRIORITY_B: begin
                    st_d.rdata[sys_ctrl_pkg::PRI_HI_POS +: 2]  = st_q.pri.tick;
                    st_d.rdata[sys_ctrl_pkg::PRI_MID_POS +: 2] = st_q.pri.pended_service;
                end
                default: begin
                    st_d.rresp = sys_ctrl_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (st_q.rvalid && s_axi_rready) begin
            st_d.rvalid  = 1'b0;
            st_d.arready = 1'b1;
        end

        // stack alignment bookkeeping around exceptions
        if (exception_entry) begin
            st_d.align_bit = stack_misaligned;
        end
        if (exception_return) begin
            st_d.restore_pad = stacked_align_bit;
        end

        // low power sequencing
        case (st_q.core)
            sys_ctrl_pkg::CORE_RUN: begin
                if (wait_for_event_instr) begin
                    if (event_q) begin
                        consume = 1'b1;
                    end else begin
                        st_d.core = sys_ctrl_pkg::CORE_WAIT;
                    end
                end else if (wait_for_interrupt_instr || (handler_to_thread && st_q.lp.sleep_exit)) begin
                    st_d.core = sys_ctrl_pkg::CORE_SLEEP;
                end
            end
            sys_ctrl_pkg::CORE_WAIT: begin
                if (event_q) begin
                    consume   = 1'b1;
                    st_d.core = sys_ctrl_pkg::CORE_RUN;
                end
            end
            sys_ctrl_pkg::CORE_SLEEP: begin
                if (enabled_event || (st_q.lp.wake_any && any_pending)) begin
                    st_d.core = sys_ctrl_pkg::CORE_RUN;
                end
            end
            default: begin
                st_d.core = sys_ctrl_pkg::CORE_RUN;
            end
        endcase
        // registered copy so the sleep output leaves a flop, not a decode
        st_d.sleeping = (st_d.core != sys_ctrl_pkg::CORE_RUN);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q         <= '0;
            st_q.awready <= 1'b1;
            st_q.wready  <= 1'b1;
            st_q.arready <= 1'b1;
            st_q.byte_order <= sys_ctrl_pkg::BYTE_ORDER_RESET;
            st_q.pri     <= {3{sys_ctrl_pkg::PRIORITY_RESET}};
            st_q.core    <= sys_ctrl_pkg::CORE_RUN;
        end else begin
            st_q <= st_d;
        end
    end

    assign s_axi_awready            = st_q.awready;
    assign s_axi_wready             = st_q.wready;
    assign s_axi_bvalid             = st_q.bvalid;
    assign s_axi_bresp              = st_q.bresp;
    assign s_axi_arready            = st_q.arready;
    assign s_axi_rvalid             = st_q.rvalid;
    assign s_axi_rdata              = st_q.rdata;
    assign s_axi_rresp              = st_q.rresp;
    assign system_reset_request     = st_q.reset_req;
    assign core_sleeping            = st_q.sleeping;
    assign deep_sleep_select        = st_q.lp.deep_sleep;
    assign hard_fault_exception     = st_q.hard_fault;
    assign status_align_bit         = st_q.align_bit;
    assign stack_restore_pad        = st_q.restore_pad;
    assign supervisor_call_priority = st_q.pri.supervisor_call;
    assign pended_service_priority  = st_q.pri.pended_service;
    assign tick_priority            = st_q.pri.tick;

    property p_key_guard;
        @(posedge aclk) disable iff (!aresetn)
        (do_write && st_q.aw_addr == sys_ctrl_pkg::OFS_RESET_CONTROL && !key_ok) |=> !system_reset_request;
    endproperty
    a_key_guard: assert property (p_key_guard) else $error("unkeyed write raised reset");
    property p_reset_req;
        @(posedge aclk) disable iff (!aresetn)
        (do_write && st_q.aw_addr == sys_ctrl_pkg::OFS_RESET_CONTROL && key_ok && wr_full
         && st_q.w_data[sys_ctrl_pkg::RESET_REQ_POS]) |=> system_reset_request ##1 !system_reset_request;
    endproperty
    a_reset_req: assert property (p_reset_req) else $error("reset request not one pulse");
    property p_ctrl_read;
        @(posedge aclk) disable iff (!aresetn)
        (do_read && s_axi_araddr == sys_ctrl_pkg::OFS_RESET_CONTROL) |=> (s_axi_rdata[31:16] == 16'h0000
            && s_axi_rdata[2:0] == 3'h0 && s_axi_rdata[15] == $past(st_q.byte_order));
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("reset control read wrong");
    property p_cfg_read;
        @(posedge aclk) disable iff (!aresetn)
        (do_read && s_axi_araddr == sys_ctrl_pkg::OFS_CONFIG_STATUS) |=> s_axi_rdata == 32'h0000_0208;
    endproperty
    a_cfg_read: assert property (p_cfg_read) else $error("config read wrong");
    property p_pri_read;
        @(posedge aclk) disable iff (!aresetn)
        (do_read && s_axi_araddr == sys_ctrl_pkg::OFS_PRIORITY_B) |=> (s_axi_rdata[29:0] & 32'h3f3f_ffff) == 32'h0;
    endproperty
    a_pri_read: assert property (p_pri_read) else $error("priority low bits not zero");
    property p_deep_sel;
        @(posedge aclk) disable iff (!aresetn)
        (do_write && st_q.aw_addr == sys_ctrl_pkg::OFS_LOW_POWER && wr_full)
            |=> deep_sleep_select == $past(st_q.w_data[2]);
    endproperty
    a_deep_sel: assert property (p_deep_sel) else $error("deep sleep select not stored");
    property p_sleep_exit;
        @(posedge aclk) disable iff (!aresetn)
        (st_q.core == sys_ctrl_pkg::CORE_RUN && !wait_for_event_instr && handler_to_thread && st_q.lp.sleep_exit)
            |=> core_sleeping;
    endproperty
    a_sleep_exit: assert property (p_sleep_exit) else $error("no sleep on handler exit");
    property p_sev_wake;
        @(posedge aclk) disable iff (!aresetn)
        (st_q.core == sys_ctrl_pkg::CORE_WAIT && send_event_instr) |-> ##[1:2] !core_sleeping;
    endproperty
    a_sev_wake: assert property (p_sev_wake) else $error("send event did not wake");
    property p_wfe_latched;
        @(posedge aclk) disable iff (!aresetn)
        (st_q.core == sys_ctrl_pkg::CORE_RUN && wait_for_event_instr && event_q) |=> !core_sleeping;
    endproperty
    a_wfe_latched: assert property (p_wfe_latched) else $error("latched event did not skip the wait");
    property p_fault;
        @(posedge aclk) disable iff (!aresetn)
        unaligned_access |=> hard_fault_exception;
    endproperty
    a_fault: assert property (p_fault) else $error("unaligned access without fault");
    property p_align;
        @(posedge aclk) disable iff (!aresetn)
        exception_entry |=> status_align_bit == $past(stack_misaligned);
    endproperty
    a_align: assert property (p_align) else $error("stacked align bit wrong");

    c_reset: cover property (@(posedge aclk) disable iff (!aresetn) system_reset_request);
    c_wait_wake: cover property (@(posedge aclk) disable iff (!aresetn)
        st_q.core == sys_ctrl_pkg::CORE_WAIT ##1 st_q.core == sys_ctrl_pkg::CORE_RUN);
    c_pri_write: cover property (@(posedge aclk) disable iff (!aresetn)
        do_write && st_q.aw_addr == sys_ctrl_pkg::OFS_PRIORITY_B);
    c_slverr: cover property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && s_axi_rresp == sys_ctrl_pkg::RESP_SLVERR);
endmodule : sys_ctrl_regs

// ==== testbench.sv ====
// Purpose: self-checking bench for the system control register bank
// Assumes: single axi4-lite master; core strobes packed in one vector
// Notes:   core_in bits: 0 wfe 1 wfi 2 sev 3 enabled 4 pending 5 to_thread 6 entry 7 return 8 misal 9 stk 10 unal
`timescale 1ns/100ps
module testbench;
    typedef struct packed { logic [4:0] a; logic [31:0] d; logic [31:0] r; } row_t;
    localparam row_t ROWS [7] = '{
        '{sys_ctrl_pkg::OFS_LOW_POWER,     32'hffffffff, 32'h00000016},
        '{sys_ctrl_pkg::OFS_PRIORITY_A,    32'hffffffff, 32'hc0000000},
        '{sys_ctrl_pkg::OFS_PRIORITY_B,    32'hffffffff, 32'hc0c00000},
        '{sys_ctrl_pkg::OFS_CONFIG_STATUS, 32'hffffffff, 32'h00000208},
        '{sys_ctrl_pkg::OFS_RESET_CONTROL, 32'h05fa0000, 32'h00000000},
        '{sys_ctrl_pkg::OFS_PRIORITY_B,    32'h40800000, 32'h40800000},
        '{sys_ctrl_pkg::OFS_PRIORITY_A,    32'h7fffffff, 32'h40000000}};
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
    logic [31:0] wdata = 32'h0, rdata, rdata_q;
    logic [3:0]  wstrb = 4'hf;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, resp_q;
    logic [10:0] core_in = 11'h0;
    logic        rst_req, sleeping, deep, hfault, align_bit, restore_pad;
    logic [1:0]  svc_pri, pend_pri, tick_pri;
    int          fails = 0, num_checks = 0, cyc = 0, req_cnt = 0;

    sys_ctrl_regs uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .wait_for_event_instr(core_in[0]), .wait_for_interrupt_instr(core_in[1]), .send_event_instr(core_in[2]),
        .enabled_event(core_in[3]), .any_pending(core_in[4]), .handler_to_thread(core_in[5]),
        .exception_entry(core_in[6]), .exception_return(core_in[7]), .stack_misaligned(core_in[8]),
        .stacked_align_bit(core_in[9]), .unaligned_access(core_in[10]), .system_reset_request(rst_req),
        .core_sleeping(sleeping), .deep_sleep_select(deep), .hard_fault_exception(hfault),
        .status_align_bit(align_bit), .stack_restore_pad(restore_pad), .supervisor_call_priority(svc_pri),
        .pended_service_priority(pend_pri), .tick_priority(tick_pri));

    always #20 aclk = ~aclk;

    // counts high cycles, so a request stuck high shows up as more than one
    always @(posedge aclk) begin
        cyc++;
        if (aresetn && rst_req) req_cnt++;
        if (cyc == 5000) begin
            fails++;
            give_verdict();
        end
    end

    task automatic give_verdict;
        $display("checks %0d failures %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        resp_q = bresp;
    endtask : wr

    task automatic rd(input logic [4:0] a);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready  <= 1'b0;
        rdata_q = rdata;
        resp_q  = rresp;
    endtask : rd

    // outputs answer one cycle after the strobe, so look on the edge after that
    task automatic pulse(input logic [10:0] m);
        @(posedge aclk);
        core_in <= m;
        @(posedge aclk);
        core_in <= 11'h0;
        @(posedge aclk);
    endtask : pulse

    // a latched wake needs one more cycle to drop the sleep state
    task automatic sleep_chk(input logic [10:0] m, input logic e);
        pulse(m);
        @(posedge aclk);
        chk("core_sleeping", 32'(e), 32'(sleeping));
    endtask : sleep_chk

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            wr(ROWS[i].a, ROWS[i].d, 4'hf);
            chk("bresp", 32'(sys_ctrl_pkg::RESP_OKAY), 32'(resp_q));
            rd(ROWS[i].a);
            chk("rdata", ROWS[i].r, rdata_q);
        end
        chk("priorities", 32'h00000019, 32'({svc_pri, pend_pri, tick_pri}));
        chk("deep_sleep_select", 32'h1, 32'(deep));
        wr(sys_ctrl_pkg::OFS_PRIORITY_B, 32'hc0000000, 4'h8);
        rd(sys_ctrl_pkg::OFS_PRIORITY_B);
        chk("rdata", 32'hc0800000, rdata_q);
        $display("test table done");
        wr(sys_ctrl_pkg::OFS_RESET_CONTROL, 32'h00000004, 4'hf);
        wr(sys_ctrl_pkg::OFS_RESET_CONTROL, 32'h05fb0004, 4'hf);
        repeat (3) @(posedge aclk);
        chk("reset_pulses", 32'h0, 32'(req_cnt));
        wr(sys_ctrl_pkg::OFS_RESET_CONTROL, 32'h05fa0004, 4'hf);
        repeat (3) @(posedge aclk);
        chk("reset_pulses", 32'h1, 32'(req_cnt));
        rd(sys_ctrl_pkg::OFS_RESET_CONTROL);
        chk("rdata", 32'h0, rdata_q);
        wr(5'h14, 32'hffffffff, 4'hf);
        chk("bresp", 32'(sys_ctrl_pkg::RESP_SLVERR), 32'(resp_q));
        rd(5'h14);
        chk("rresp", 32'(sys_ctrl_pkg::RESP_SLVERR), 32'(resp_q));
        $display("test reset control done");
        sleep_chk(11'h001, 1'b1);
        sleep_chk(11'h010, 1'b0);
        wr(sys_ctrl_pkg::OFS_LOW_POWER, 32'h00000002, 4'hf);
        chk("deep_sleep_select", 32'h0, 32'(deep));
        sleep_chk(11'h001, 1'b1);
        sleep_chk(11'h010, 1'b1);
        sleep_chk(11'h004, 1'b0);
        sleep_chk(11'h008, 1'b0);
        sleep_chk(11'h001, 1'b0);
        sleep_chk(11'h020, 1'b1);
        sleep_chk(11'h008, 1'b0);
        sleep_chk(11'h002, 1'b1);
        sleep_chk(11'h008, 1'b0);
        wr(sys_ctrl_pkg::OFS_LOW_POWER, 32'h00000000, 4'hf);
        sleep_chk(11'h020, 1'b0);
        $display("test sleep done");
        pulse(11'h400);
        chk("hard_fault_exception", 32'h1, 32'(hfault));
        pulse(11'h140);
        chk("status_align_bit", 32'h1, 32'(align_bit));
        pulse(11'h040);
        chk("status_align_bit", 32'h0, 32'(align_bit));
        pulse(11'h280);
        chk("stack_restore_pad", 32'h1, 32'(restore_pad));
        $display("test exception done");
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("priorities", 32'h0, 32'({svc_pri, pend_pri, tick_pri}));
        rd(sys_ctrl_pkg::OFS_PRIORITY_B);
        chk("rdata", 32'h0, rdata_q);
        $display("test second reset done");
        give_verdict();
    end
endmodule : testbench
